/* File: rtl/sps_cfg.svh */
// Timing and code constants for the switchgear position supervisor
// Assumes a 10 MHz core clock; times are given in milliseconds
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

// ********************************************************************
// Position codes
// ********************************************************************
`define SPS_POS_INDET 2'h0
`define SPS_POS_OPEN 2'h1
`define SPS_POS_CLOSED 2'h2
`define SPS_POS_DISTURB 2'h3

// ********************************************************************
// Timer widths and clock rate
// ********************************************************************
`define SPS_TMR_W 16
`define SPS_CLK_KHZ 10000
`define SPS_MS_DIV 10000
`define SPS_MS_LAST 14'h270f
`define SPS_TMR_ONE 16'h0001
`define SPS_DIV_W 14
`define SPS_TMR_ZERO 16'h0000
`define SPS_DIV_ZERO 14'h0000

`endif

/* File: rtl/sps_pkg.sv */
// Types shared by the switchgear position supervisor
// Assumes sps_cfg.svh is available for constants
package sps_pkg;

	// Supervision phase of one switching element
	typedef enum logic [2:0] {
		SPS_IDLE = 3'h0,
		SPS_MOVE = 3'h1,
		SPS_DWELL = 3'h3,
		SPS_FAIL = 3'h2
	} sps_phase_t;

endpackage

/* File: rtl/sps_supervisor.sv */
// Position supervisor for one controllable switchgear
// Assumes contact inputs already synchronous and debounced
`include "sps_cfg.svh"

module sps_supervisor
	import sps_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Contact inputs and wiring configuration
	input wire logic aux_closed,
	input wire logic aux_open,
	input wire logic closed_wired,
	input wire logic open_wired,
	input wire logic plug_removed,
	// Commands from control
	input wire logic close_req,
	input wire logic open_req,
	// Moving and dwell times in ms
	input wire logic [15:0] t_move_close,
	input wire logic [15:0] t_move_open,
	input wire logic [15:0] t_dwell,
	// Command relays
	output logic close_cmd,
	output logic open_cmd,
	// Position indications
	output logic pos_closed,
	output logic pos_open,
	output logic pos_indet,
	output logic pos_disturb,
	output logic [1:0] pos_code,
	output logic removed,
	output logic one_contact_flag,
	output logic pos_changed
);

	// Checks below sample on the core clock and pause in reset
	default clocking cb_core @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// ********************************************************************
	// Millisecond tick
	// ********************************************************************
	logic [`SPS_DIV_W-1:0] div_r; // Prescaler count
	logic ms_tick; // One-cycle pulse per millisecond

	assign ms_tick = (div_r == `SPS_MS_LAST);

	// Free-running prescaler
	always_ff @(posedge core_clk) begin
		if (sys_rst || ms_tick) begin
			div_r <= `SPS_DIV_ZERO;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// ********************************************************************
	// Supervision state
	// ********************************************************************
	sps_phase_t phase_r; // Current phase
	logic dir_close_r; // Direction of the running operation
	logic [`SPS_TMR_W-1:0] tmr_r; // Remaining ms in move or dwell
	logic single; // Only one contact wired
	logic feedback_ok; // Expected end position seen
	logic supervised; // Direction covered by a contact
	logic start_close; // Close request accepted this cycle
	logic start_open; // Open request accepted this cycle
	logic tmr_done; // Running time ends at this tick

	assign single = closed_wired ^ open_wired;
	assign one_contact_flag = single;
	// Open takes priority; switching allowed regardless of truck
	assign start_open = open_req && (phase_r != SPS_MOVE);
	assign start_close = close_req && !open_req
		&& (phase_r != SPS_MOVE);
	assign tmr_done = ms_tick && (tmr_r <= `SPS_TMR_ONE);

	// Expected feedback per direction and wiring
	always_comb begin
		if (dir_close_r) begin
			feedback_ok = closed_wired
				? (aux_closed && !(open_wired && aux_open)) : !aux_open;
		end else begin
			feedback_ok = open_wired ? (aux_open && !aux_closed)
				: !aux_closed;
		end
	end

	// One contact supervises only its own direction
	always_comb begin
		if (!single) begin
			supervised = 1'b1;
		end else if (dir_close_r) begin
			supervised = closed_wired;
		end else begin
			supervised = open_wired;
		end
	end

	// Phase sequencing: move, optional dwell, fail
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_r <= SPS_IDLE;
			dir_close_r <= 1'b0;
			tmr_r <= `SPS_TMR_ZERO;
		end else if (start_open || start_close) begin
			phase_r <= SPS_MOVE;
			dir_close_r <= start_close;
			tmr_r <= start_close ? t_move_close : t_move_open;
		end else begin
			unique case (phase_r)
				SPS_MOVE: begin
					if (feedback_ok) begin
						phase_r <= SPS_IDLE;
					end else if (tmr_done && !supervised) begin
						// Unwatched direction: time only bounds the pulse
						phase_r <= SPS_IDLE;
					end else if (tmr_done) begin
						if (t_dwell != `SPS_TMR_ZERO) begin
							phase_r <= SPS_DWELL;
							tmr_r <= t_dwell;
						end else begin
							phase_r <= SPS_FAIL;
						end
					end else if (ms_tick) begin
						tmr_r <= tmr_r - 1'b1;
					end
				end
				SPS_DWELL: begin
					if (tmr_done) begin
						phase_r <= feedback_ok ? SPS_IDLE : SPS_FAIL;
					end else if (ms_tick) begin
						tmr_r <= tmr_r - 1'b1;
					end
				end
				SPS_FAIL: begin
					// Leaves once contacts show a valid position
					if (aux_closed != aux_open) begin
						phase_r <= SPS_IDLE;
					end
				end
				SPS_IDLE: begin
					phase_r <= SPS_IDLE;
				end
				default: begin
					phase_r <= SPS_IDLE;
				end
			endcase
		end
	end

	// ********************************************************************
	// Command outputs
	// ********************************************************************
	// Command stands only while moving time runs
	assign close_cmd = (phase_r == SPS_MOVE) && dir_close_r
		&& !feedback_ok;
	assign open_cmd = (phase_r == SPS_MOVE) && !dir_close_r
		&& !feedback_ok;

	// Milliseconds seen while a command stands; feeds the time checks
	logic [`SPS_TMR_W-1:0] cmd_ms_r;

	// Restarts whenever no command stands
	always_ff @(posedge core_clk) begin
		if (sys_rst || !(close_cmd || open_cmd)) begin
			cmd_ms_r <= `SPS_TMR_ZERO;
		end else if (ms_tick) begin
			cmd_ms_r <= cmd_ms_r + 1'b1;
		end
	end

	// ********************************************************************
	// Position derivation
	// ********************************************************************
	logic [1:0] code_nxt; // Validated code this cycle
	logic [1:0] code_r; // Registered code
	logic removed_r;
	logic moving;

	assign moving = ((phase_r == SPS_MOVE) || (phase_r == SPS_DWELL))
		&& supervised;

	// Decode contacts into a position code
	always_comb begin
		if (plug_removed) begin
			code_nxt = `SPS_POS_OPEN;
		end else if (!closed_wired && !open_wired) begin
			code_nxt = `SPS_POS_DISTURB;
		end else if (single) begin
			// No disturbed from contacts alone
			if (moving) begin
				code_nxt = `SPS_POS_INDET;
			end else if (phase_r == SPS_FAIL) begin
				code_nxt = `SPS_POS_DISTURB;
			end else if (closed_wired) begin
				code_nxt = aux_closed ? `SPS_POS_CLOSED
					: `SPS_POS_OPEN;
			end else begin
				code_nxt = aux_open ? `SPS_POS_OPEN
					: `SPS_POS_CLOSED;
			end
		end else if (aux_closed != aux_open) begin
			code_nxt = aux_closed ? `SPS_POS_CLOSED
				: `SPS_POS_OPEN;
		end else if (moving) begin
			code_nxt = `SPS_POS_INDET;
		end else begin
			code_nxt = `SPS_POS_DISTURB;
		end
	end

	// Register the code; reset loads the indeterminate code
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			code_r <= `SPS_POS_INDET;
		end else begin
			code_r <= code_nxt;
		end
	end

	// Removed supervision state follows the plug
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			removed_r <= 1'b0;
		end else begin
			removed_r <= plug_removed;
		end
	end

	// Change pulse for the display symbol
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pos_changed <= 1'b0;
		end else begin
			pos_changed <= (code_nxt != code_r);
		end
	end

	assign pos_code = code_r;
	assign removed = removed_r;
	assign pos_closed = (code_r == `SPS_POS_CLOSED);
	assign pos_open = (code_r == `SPS_POS_OPEN);
	assign pos_indet = (code_r == `SPS_POS_INDET);
	assign pos_disturb = (code_r == `SPS_POS_DISTURB);

	// ********************************************************************
	// Checks
	// ********************************************************************
	// Plug withdrawn this cycle
	sequence s_removed;
		plug_removed;
	endsequence

	// Close command standing, then both contacts show closed
	sequence s_close_fed;
		close_cmd ##1 (!single && closed_wired && aux_closed && !aux_open);
	endsequence

	// Decoding of the code and of the two-contact table
	AST_CODE_ONEHOT: assert property (
		$onehot({pos_closed, pos_open, pos_indet, pos_disturb}))
		else $error("position indications not one-hot");
	AST_OPEN_DECODE: assert property (
		!single && closed_wired && !aux_closed && aux_open && !plug_removed
		|=> pos_code == `SPS_POS_OPEN)
		else $error("01 contacts not decoded as open");
	AST_CLOSED_DECODE: assert property (
		!single && closed_wired && aux_closed && !aux_open && !plug_removed
		|=> pos_closed && !pos_open && !pos_disturb)
		else $error("10 contacts not decoded as closed");
	AST_START_INDET: assert property (
		(phase_r == SPS_MOVE) && !single && closed_wired && !plug_removed
		&& (aux_closed == aux_open) |=> pos_indet)
		else $error("running move not indeterminate");
	AST_DWELL_INDET: assert property (
		(phase_r == SPS_DWELL) && !single && closed_wired && !plug_removed
		&& (aux_closed == aux_open) |=> pos_indet)
		else $error("dwell not indeterminate");
	AST_FAIL_DISTURB: assert property (
		(phase_r == SPS_FAIL) && !plug_removed && aux_closed == aux_open
		&& !start_open && !start_close |=> pos_disturb)
		else $error("failed move not disturbed");
	AST_NONE_WIRED: assert property (
		!closed_wired && !open_wired && !plug_removed |=> pos_disturb)
		else $error("unwired contacts not disturbed");

	// Withdrawn element
	AST_REMOVED_OPEN: assert property (
		s_removed |=> pos_open && removed)
		else $error("removed element not reported open");
	AST_REMOVED_SWITCH: assert property (
		start_close && plug_removed && !single && !aux_closed && aux_open
		|=> close_cmd)
		else $error("close refused while withdrawn");

	// Command pulses
	AST_CMD_BOUND: assert property (
		s_close_fed |=> !close_cmd)
		else $error("close command outlived feedback");
	AST_CLOSE_TIME: assert property (
		close_cmd |-> cmd_ms_r <= t_move_close)
		else $error("close command outlived its moving time");
	AST_OPEN_TIME: assert property (
		open_cmd |-> cmd_ms_r <= t_move_open)
		else $error("open command outlived its moving time");
	AST_OPEN_CMD: assert property (
		start_open |=> open_cmd || pos_open)
		else $error("open command not issued");

	// Single contact and display pulse
	AST_FLAG: assert property (
		one_contact_flag && !plug_removed && (phase_r == SPS_IDLE)
		|=> !pos_indet && !pos_disturb)
		else $error("single contact gave indet or disturbed");
	AST_CHANGE: assert property (
		!$stable(pos_code) |-> pos_changed)
		else $error("display change pulse missing");
	AST_CHANGE_ONLY: assert property (
		pos_changed |-> !$stable(pos_code))
		else $error("display pulse without a change");

endmodule

/* File: dv/sps_gear_model.sv */
// Behavioural switchgear with auxiliary contacts and a travel delay
// Assumes commands and reset share the supervisor's core clock
module sps_gear_model #(
	parameter int LAT = 40
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Command relays and fault control
	input wire logic close_cmd,
	input wire logic open_cmd,
	input wire logic jam,
	// Auxiliary contacts
	output logic aux_closed,
	output logic aux_open
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Mechanism state
	// ****************************************************************
	logic shut_r; // Main contacts closed
	logic goal_r; // Target of the current travel
	logic moving_r; // Travel in progress
	int cnt_r; // Remaining travel cycles

	// Travel starts on a command and ends after LAT unless jammed
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shut_r <= 1'b0;
			moving_r <= 1'b0;
			goal_r <= 1'b0;
			cnt_r <= 0;
		end else if (moving_r) begin
			// A jam leaves the mechanism stuck between end positions
			if (cnt_r > 0)
				cnt_r <= cnt_r - 1;
			else if (!jam) begin
				shut_r <= goal_r;
				moving_r <= 1'b0;
			end
		end else if (open_cmd && shut_r) begin
			goal_r <= 1'b0;
			moving_r <= 1'b1;
			cnt_r <= LAT;
		end else if (close_cmd && !shut_r) begin
			goal_r <= 1'b1;
			moving_r <= 1'b1;
			cnt_r <= LAT;
		end
	end

	// Both contacts open while travelling
	assign aux_closed = !moving_r && shut_r;
	assign aux_open = !moving_r && !shut_r;
endmodule

/* File: dv/switchgear_position_supervisor_tb.sv */
// Self-checking bench for the switchgear position supervisor
// Assumes the behavioural gear model and a 10 MHz core clock
`include "sps_cfg.svh"

module switchgear_position_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic closed_wired = 1'b1; // Both contacts wired
	logic open_wired = 1'b1;
	logic plug_removed = 1'b0;
	logic close_req = 1'b0;
	logic open_req = 1'b0;
	logic jam = 1'b0;
	logic [15:0] t_move_close = 16'h0002;
	logic [15:0] t_move_open = 16'h0003;
	logic [15:0] t_dwell = 16'h0000;
	logic aux_closed, aux_open, close_cmd, open_cmd, pos_changed;
	logic pos_closed, pos_open, pos_indet, pos_disturb, removed;
	logic one_contact_flag;
	logic [1:0] pos_code;
	int n_mismatch = 0;
	int checked = 0;
	int n_change = 0;
	int len;

	// ****************************************************************
	// Instances, clock and change monitor
	// ****************************************************************
	sps_supervisor u_sps_supervisor (.core_clk(core_clk),
		.sys_rst(sys_rst), .aux_closed(aux_closed), .aux_open(aux_open),
		.closed_wired(closed_wired), .open_wired(open_wired),
		.plug_removed(plug_removed), .close_req(close_req),
		.open_req(open_req), .t_move_close(t_move_close),
		.t_move_open(t_move_open), .t_dwell(t_dwell),
		.close_cmd(close_cmd), .open_cmd(open_cmd),
		.pos_closed(pos_closed), .pos_open(pos_open),
		.pos_indet(pos_indet), .pos_disturb(pos_disturb),
		.pos_code(pos_code), .removed(removed),
		.one_contact_flag(one_contact_flag), .pos_changed(pos_changed));
	sps_gear_model u_sps_gear_model (.core_clk(core_clk),
		.sys_rst(sys_rst), .close_cmd(close_cmd), .open_cmd(open_cmd),
		.jam(jam), .aux_closed(aux_closed), .aux_open(aux_open));

	always #50 core_clk = ~core_clk;

	// Count display update pulses
	always @(posedge core_clk) begin
		if (pos_changed === 1'b1)
			n_change++;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// Bounded wait for a position code; a timeout ends the run
	task automatic wait_code(input logic [1:0] exp, input int bound);
		for (int i = 0; i < bound && pos_code !== exp; i++)
			@(negedge core_clk);
		chk(pos_code, exp);
		if (pos_code !== exp)
			summarize();
	endtask

	// One-cycle request, then settle past the command edge
	task automatic req(input logic to_close);
		@(posedge core_clk);
		close_req <= to_close;
		open_req <= !to_close;
		@(posedge core_clk);
		close_req <= 1'b0;
		open_req <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
	endtask

	// Measure how long a command output stays high
	task automatic cmd_len();
		len = 0;
		while ((close_cmd | open_cmd) === 1'b1 && len < 40000) begin
			@(negedge core_clk);
			len++;
		end
		// A command that never drops ends the run
		if ((close_cmd | open_cmd) !== 1'b0) begin
			chk(1'b1, 1'b0);
			summarize();
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk({close_cmd, open_cmd, pos_changed}, 3'h0);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		wait_code(`SPS_POS_OPEN, 4);
		chk({pos_closed, pos_open, pos_indet, pos_disturb}, 4'h4);
		chk(one_contact_flag, 1'b0);
		// Close with prompt feedback
		cyc(1);
		len = n_change;
		req(1'b1);
		chk(close_cmd, 1'b1);
		cyc(3);
		chk({pos_code, pos_indet}, 3'h1);
		wait_code(`SPS_POS_CLOSED, 100);
		chk({close_cmd, pos_closed, pos_open}, 3'h2);
		cyc(1);
		chk(n_change - len, 16'h0002);
		// Open with prompt feedback
		req(1'b0);
		chk(open_cmd, 1'b1);
		cyc(3);
		chk(pos_indet, 1'b1);
		wait_code(`SPS_POS_OPEN, 100);
		chk(open_cmd, 1'b0);
		// Close that sticks mid-travel
		@(posedge core_clk);
		jam <= 1'b1;
		req(1'b1);
		cmd_len();
		chk(len >= 9990 && len <= 20010, 1'b1);
		wait_code(`SPS_POS_DISTURB, 4);
		chk({pos_indet, pos_disturb}, 2'h1);
		@(posedge core_clk);
		jam <= 1'b0;
		wait_code(`SPS_POS_CLOSED, 100);
		// Open that sticks, with a dwell time
		@(posedge core_clk);
		jam <= 1'b1;
		t_dwell <= 16'h0001;
		req(1'b0);
		cmd_len();
		chk(len >= 19990 && len <= 30010, 1'b1);
		cyc(2);
		chk(pos_code, `SPS_POS_INDET);
		wait_code(`SPS_POS_DISTURB, 25000);
		@(posedge core_clk);
		jam <= 1'b0;
		t_dwell <= 16'h0000;
		wait_code(`SPS_POS_OPEN, 100);
		// Plug withdrawn while open
		@(posedge core_clk);
		plug_removed <= 1'b1;
		cyc(2);
		chk({removed, pos_code}, 3'h5);
		req(1'b1);
		chk(close_cmd, 1'b1);
		cyc(100);
		chk({aux_closed, pos_code}, 3'h5);
		@(posedge core_clk);
		plug_removed <= 1'b0;
		wait_code(`SPS_POS_CLOSED, 10);
		// Only the closed contact wired
		@(posedge core_clk);
		open_wired <= 1'b0;
		cyc(2);
		chk({one_contact_flag, pos_code}, 3'h6);
		req(1'b0);
		wait_code(`SPS_POS_OPEN, 100);
		req(1'b1);
		chk(pos_code, `SPS_POS_INDET);
		wait_code(`SPS_POS_CLOSED, 100);
		// Only the open contact wired
		@(posedge core_clk);
		closed_wired <= 1'b0;
		open_wired <= 1'b1;
		cyc(2);
		chk({one_contact_flag, pos_code}, 3'h6);
		// No contact wired at all
		@(posedge core_clk);
		open_wired <= 1'b0;
		cyc(2);
		chk(pos_code, `SPS_POS_DISTURB);
		summarize();
	end
endmodule
